// >>> rtl/sdf_cfg.svh
// Constants of the two-channel sigma-delta decimation filter.
// Summary of operation
// - Each channel averages the bitstream and yields one word per ratio count of modulator ticks.
// - Eight ratios are offered through a three-bit field, the powers of two from 128 to 16384.
// - Word rates follow the main clock, from 32 kSPS at the fastest clock to 62.5 SPS at the slowest.
// - The modulator tick, which clocks the filter input, runs at half the main clock.
// - The bitstream feeds a third-order sinc path and a fast-settling path side by side.
// - After reset the first conversions come from the fast path, a first-order averager.
// - After two fast conversions the output moves to the sinc3 path and stays there until reset.
// - For ratios 128 to 1024 the sinc3 stage decimates by the full ratio and feeds the output.
// - For ratios 2048 and up sinc3 runs at 1024, followed by a sinc1 stage decimating by 2 to 16.
// - The sinc3 stage is the cube of an N-tap moving sum over N, built as integrators and combs.
// - The response has nulls at multiples of the word rate, repeating at the modulator rate.
// - Enabling a channel, changing its input or gain, or a resync restarts its settling.
// - Settling takes 432, 816, 1584, 3120, 6192, 10288, 18480 or 34864 modulator periods.
// - Unsettled words are neither suppressed nor flagged and keep their normal ready indication.
`ifndef SDF_CFG_SVH
`define SDF_CFG_SVH
`define SDF_CTRL_ADDR   4'h0
`define SDF_STATUS_ADDR 4'h4
`define SDF_RESYNC_BIT  8
`define SDF_CTRL_RST    3'h0
`define SDF_EN_RST      2'h3
`define SDF_MOD_DIV     2
`define SDF_BASE_LEN    15'h0080
`define SDF_SINC3_MASK  14'h03FF
`define SDF_SETTLE_0    16'h01B0
`define SDF_SETTLE_1    16'h0330
`define SDF_SETTLE_2    16'h0630
`define SDF_SETTLE_3    16'h0C30
`define SDF_SETTLE_4    16'h1830
`define SDF_SETTLE_5    16'h2830
`define SDF_SETTLE_6    16'h4830
`define SDF_SETTLE_7    16'h8830
`endif

// >>> rtl/sdf_pkg.sv
// Types shared by the decimation filter.
package sdf_pkg;
  typedef enum logic [1:0] {
    SDF_FAST  = 2'b01,
    SDF_SINC3 = 2'b10
  } sdf_path_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sdf_bus_t;

  typedef struct packed {
    logic [23:0] ch1;
    logic [23:0] ch0;
  } sdf_word_t;

  typedef struct packed {
    logic                 mod_ph;
    logic [13:0]          phase;
    logic [1:0]           conv;
    sdf_path_t            path;
    logic [2:0]           osr;
    logic [1:0]           en;
    logic [1:0][31:0]     i1;
    logic [1:0][31:0]     i2;
    logic [1:0][31:0]     i3;
    logic [1:0][31:0]     d1;
    logic [1:0][31:0]     d2;
    logic [1:0][31:0]     d3;
    logic [1:0][35:0]     acc1;
    logic [1:0][15:0]     fast;
    logic [1:0][15:0]     settle;
    logic [1:0]           v;
    logic [1:0][47:0]     buf_w;
    logic                 ovr;
    logic                 data_ready_n_n;
    logic [31:0]          rd_data;
  } sdf_state_t;
endpackage

// >>> rtl/sdf_filter.sv
// Two-channel decimation filter with register port and two-entry output buffer.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "sdf_cfg.svh"
module sdf_filter import sdf_pkg::*; (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire sdf_bus_t   bus_in,
  output logic [31:0]     rd_data_out,
  input  wire logic [1:0] mod_bit_in,
  input  wire logic [1:0] cfg_change_in,
  output sdf_word_t       word_out,
  output logic            valid_out,
  input  wire logic       ready_in,
  output logic            data_ready_n_out
);
  sdf_state_t       s;
  sdf_state_t       n;
  logic             tick;
  logic             full;
  logic             dump3;
  logic             wr_ctrl;
  logic             resync;
  logic             osr_chg;
  logic             pop;
  logic [14:0]      len;
  logic [13:0]      m3;
  logic [15:0]      limit;
  logic [3:0]       k;
  logic [1:0]       restart;
  logic [1:0][31:0] x;
  logic [1:0][31:0] y1;
  logic [1:0][31:0] y2;
  logic [1:0][31:0] y3;
  logic [1:0][31:0] y3s;
  logic [1:0][35:0] s1;
  logic [1:0][31:0] fs;
  logic [47:0]      word;

  // Ratio decode: code 0 is 128 and each code doubles the length.
  // ratio code decode
  always_comb begin
    len = `SDF_BASE_LEN << s.osr;
    k   = 4'(s.osr) + 4'h7;
    m3  = (s.osr >= 3'h3) ? `SDF_SINC3_MASK : 14'(len - 15'h0001);
    unique case (s.osr)
      3'h0: limit = `SDF_SETTLE_0;
      3'h1: limit = `SDF_SETTLE_1;
      3'h2: limit = `SDF_SETTLE_2;
      3'h3: limit = `SDF_SETTLE_3;
      3'h4: limit = `SDF_SETTLE_4;
      3'h5: limit = `SDF_SETTLE_5;
      3'h6: limit = `SDF_SETTLE_6;
      3'h7: limit = `SDF_SETTLE_7;
    endcase
  end

  // Next-state logic for the whole block.
  always_comb begin
    n       = s;
    x       = '0;
    y1      = '0;
    y2      = '0;
    y3      = '0;
    y3s     = '0;
    s1      = '0;
    fs      = '0;
    word    = '0;
    restart = '0;
    tick     = s.mod_ph;
    n.mod_ph = ~s.mod_ph;
    wr_ctrl  = bus_in.wr && (bus_in.addr == `SDF_CTRL_ADDR);
    resync   = wr_ctrl && bus_in.wdata[`SDF_RESYNC_BIT];
    osr_chg  = wr_ctrl && (bus_in.wdata[2:0] != s.osr);
    if (wr_ctrl) begin
      n.osr = bus_in.wdata[2:0];
      n.en  = bus_in.wdata[5:4];
    end
    // sinc3 dumps every 1024 ticks for large ratios
    dump3 = tick && ((s.phase & m3) == m3);
    // one word per ratio count of ticks
    full  = tick && (s.phase == 14'(len - 15'h0001));
    if (tick) begin
      n.phase = full ? 14'h0000 : s.phase + 14'h0001;
    end
    // one shared phase for both channels
    if (resync || osr_chg) begin
      n.phase = 14'h0000;
    end
    // both paths run on every channel
    for (int c = 0; c < 2; c++) begin
      x[c] = mod_bit_in[c] ? 32'h0000_0001 : 32'hFFFF_FFFF;
      if (tick) begin
        n.i1[c] = s.i1[c] + x[c];
        n.i2[c] = s.i2[c] + s.i1[c];
        n.i3[c] = s.i3[c] + s.i2[c];
      end
      // combs run at the sinc3 dump rate
      y1[c] = s.i3[c] - s.d1[c];
      y2[c] = y1[c] - s.d2[c];
      y3[c] = y2[c] - s.d3[c];
      unique case (k)
        4'h7:    y3s[c] = y3[c] <<< 9;
        4'h8:    y3s[c] = y3[c] <<< 6;
        4'h9:    y3s[c] = y3[c] <<< 3;
        default: y3s[c] = y3[c];
      endcase
      // sinc1 stage sums the sinc3 words
      s1[c] = s.acc1[c] + {{4{y3s[c][31]}}, y3s[c]};
      if (dump3) begin
        n.d1[c]   = s.i3[c];
        n.d2[c]   = y1[c];
        n.d3[c]   = y2[c];
        n.acc1[c] = full ? 36'h0_0000_0000 : s1[c];
      end
      // fast path is a plain average over the ratio
      fs[c] = {{16{s.fast[c][15]}}, s.fast[c]} + x[c];
      if (tick) begin
        n.fast[c] = full ? 16'h0000 : fs[c][15:0];
      end
      // restart of settling clears the sinc state
      restart[c] = resync || osr_chg || cfg_change_in[c] || !s.en[c]
                   || (wr_ctrl && bus_in.wdata[4 + c] && !s.en[c]);
      if (restart[c]) begin
        n.i1[c]     = '0;
        n.i2[c]     = '0;
        n.i3[c]     = '0;
        n.d1[c]     = '0;
        n.d2[c]     = '0;
        n.d3[c]     = '0;
        n.acc1[c]   = '0;
        n.settle[c] = 16'h0000;
      end else if (tick && (s.settle[c] != limit)) begin
        // settling time counted in modulator periods
        n.settle[c] = s.settle[c] + 16'h0001;
      end
      if (s.path == SDF_FAST) begin
        word[24*c +: 24] = 24'((fs[c] <<< (5'd30 - 5'(k))) >>> 8);
      end else if (s.osr < 3'h4) begin
        word[24*c +: 24] = y3s[c][31:8];
      end else begin
        word[24*c +: 24] = 24'((s1[c] >>> (k - 4'hA)) >>> 8);
      end
    end
    // two fast words, then sinc3 until reset
    unique case (s.path)
      SDF_FAST: begin
        if (full) begin
          n.conv = s.conv + 2'h1;
          if (s.conv == 2'h1) begin
            n.path = SDF_SINC3;
          end
        end
      end
      SDF_SINC3: begin
        n.path = SDF_SINC3;
      end
      default: begin
        n.path = SDF_FAST;
      end
    endcase
    // Drain first so that a full buffer popped this cycle still takes the word.
    pop = s.v[0] && ready_in;
    if (pop) begin
      n.buf_w[0] = s.buf_w[1];
      n.v        = {1'b0, s.v[1]};
    end
    if (bus_in.rd && (bus_in.addr == `SDF_STATUS_ADDR)) begin
      n.ovr = 1'b0;
    end
    // every word that finds a free entry is pushed, settled or not
    if (full) begin
      if (!n.v[0]) begin
        n.buf_w[0] = word;
        n.v[0]     = 1'b1;
      end else if (!n.v[1]) begin
        n.buf_w[1] = word;
        n.v[1]     = 1'b1;
      end else begin
        n.ovr = 1'b1;
      end
    end
    n.data_ready_n_n  = ~n.v[0];
    n.rd_data = 32'h0000_0000;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        `SDF_CTRL_ADDR:   n.rd_data = {26'h000_0000, s.en, 1'b0, s.osr};
        `SDF_STATUS_ADDR: n.rd_data = {28'h000_0000, s.ovr, s.path == SDF_SINC3,
                                       s.settle[1] == limit, s.settle[0] == limit};
        default:          n.rd_data = 32'h0000_0000;
      endcase
    end
  end

  // State register; a reset always starts on the fast path.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s        <= '0;
      s.path   <= SDF_FAST;
      s.osr    <= `SDF_CTRL_RST;
      s.en     <= `SDF_EN_RST;
      s.data_ready_n_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign rd_data_out      = s.rd_data;
  assign word_out         = s.buf_w[0];
  assign valid_out        = s.v[0];
  assign data_ready_n_out = s.data_ready_n_n;

  // Clocks since the last word, to check the word spacing.
  logic [15:0] gap;
  logic        clean;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap   <= 16'h0000;
      clean <= 1'b0;
    end else begin
      gap   <= full ? 16'h0000 : gap + 16'h0001;
      clean <= (resync || osr_chg) ? 1'b0 : (full ? 1'b1 : clean);
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_word_gap;
    full && clean && !$past(resync || osr_chg) |-> gap == 16'(2 * len - 1);
  endproperty
  a_word_gap: assert property (p_word_gap) else $error("word spacing wrong");
  property p_top_ratio;
    (s.osr == 3'h7) && full |-> s.phase == 14'h3FFF;
  endproperty
  a_top_ratio: assert property (p_top_ratio) else $error("ratio 16384 misdecoded");
  property p_tick;
    tick |=> !tick ##1 tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick not half rate");
  property p_fast_first;
    s.conv < 2'h2 |-> s.path == SDF_FAST;
  endproperty
  a_fast_first: assert property (p_fast_first) else $error("left fast path early");
  property p_switch;
    (s.path == SDF_FAST) && full && (s.conv == 2'h1) |=> s.path == SDF_SINC3;
  endproperty
  a_switch: assert property (p_switch) else $error("no switch to sinc3");
  property p_stay;
    s.path == SDF_SINC3 |=> s.path == SDF_SINC3 [*2];
  endproperty
  a_stay: assert property (p_stay) else $error("left sinc3 path");
  property p_small_dump;
    dump3 && (s.osr < 3'h4) |-> full;
  endproperty
  a_small_dump: assert property (p_small_dump) else $error("sinc3 dump off word");
  property p_big_dump;
    dump3 && (s.osr > 3'h3) |-> s.phase[9:0] == 10'h3FF;
  endproperty
  a_big_dump: assert property (p_big_dump) else $error("sinc3 not at 1024");
  property p_resync;
    resync |=> s.phase == 14'h0000 && s.settle == '0;
  endproperty
  a_resync: assert property (p_resync) else $error("resync did not restart");
  property p_present;
    full && !s.v[1] |=> valid_out && !data_ready_n_out;
  endproperty
  a_present: assert property (p_present) else $error("word not presented");
  property p_hold;
    valid_out && !ready_in |=> valid_out && $stable(word_out);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word lost");

  c_switch:  cover property (s.path == SDF_FAST ##1 s.path == SDF_SINC3);
  c_sinc1:   cover property (full && (s.osr == 3'h4) && (s.path == SDF_SINC3));
  c_overrun: cover property ($rose(s.ovr));
  c_stall:   cover property (valid_out && !ready_in [*3]);
endmodule

// >>> tb/sdf_partner.sv
// Far-side model: modulator bitstream source and word consumer.
`timescale 1ns/1ps
module sdf_partner import sdf_pkg::*; (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] pattern_in,
  input  wire logic       stall_in,
  output logic [1:0]      mod_bit_out,
  output logic            ready_out
);
  logic [1:0] div;
  logic       bit0;

  // tick rate: bit changes every second clock, so alternate ticks see opposite bits.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end

  // Pattern 0 is plus full scale, 1 minus full scale, 2 a tone at half the tick rate.
  always_comb begin
    case (pattern_in)
      2'h0:    bit0 = 1'b1;
      2'h1:    bit0 = 1'b0;
      default: bit0 = div[1];
    endcase
  end

  // Channel 1 carries the inverse so a swapped channel shows up as a sign error.
  assign mod_bit_out = {~bit0, bit0};

  // host discard: the consumer takes every word while stall_in is low; the bench alone judges settling.
  assign ready_out = ~stall_in;
endmodule

// >>> tb/test_sigma_delta_decimation_filter.sv
// Self-checking bench for the two-channel decimation filter.
`timescale 1ns/1ps
module test_sigma_delta_decimation_filter import sdf_pkg::*;;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  sdf_bus_t    bus      = '0;
  logic [1:0]  cfg      = 2'h0;
  logic [1:0]  pat      = 2'h0;
  logic        stall    = 1'b0;
  logic [31:0] rd_data;
  logic [31:0] d;
  logic [1:0]  mod_bit;
  logic        ready;
  logic        valid;
  logic        data_ready_n_n;
  sdf_word_t   word;
  int          n_mismatch      = 0;
  int          samples_checked = 0;
  int          cyc             = 0;
  int          n;

  // Clock at 25 MHz.
  initial forever #20 clk_in = ~clk_in;

  sdf_filter i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rd_data_out(rd_data),
    .mod_bit_in(mod_bit), .cfg_change_in(cfg), .word_out(word), .valid_out(valid),
    .ready_in(ready), .data_ready_n_out(data_ready_n_n));

  sdf_partner i_far (.clk_in(clk_in), .rst_n_in(rst_n_in), .pattern_in(pat),
    .stall_in(stall), .mod_bit_out(mod_bit), .ready_out(ready));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Ceiling sits well above the roughly 75000 cycles the sequence needs.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is sampled just there.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 v = rd_data;
  endtask

  // Counts edges until the next word shows; bounded by the slowest ratio.
  task automatic next_word(output int c);
    c = 0;
    do begin
      @(posedge clk_in);
      #1 c++;
    end while (valid !== 1'b1 && c < 40000);
  endtask

  task automatic chk_word(input logic [23:0] e0, input logic [23:0] e1);
    chk({8'h00, word.ch0}, {8'h00, e0});
    chk({8'h00, word.ch1}, {8'h00, e1});
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk({30'h0, valid, data_ready_n_n}, 32'h0000_0001);
    rd(4'h0, d); chk(d, 32'h0000_0030);
    rd(4'h8, d); chk(d, 32'h0000_0000);
    chk(rd_data, 32'h0000_0000);
    next_word(n);
    chk({31'h0, data_ready_n_n}, 32'h0000_0000);
    rd(4'h4, d); chk(d & 32'h4, 32'h0000_0000);
    next_word(n);
    next_word(n); chk(32'(n), 32'h0000_0100);
    rd(4'h4, d); chk(d & 32'h4, 32'h0000_0004);
    repeat (4) next_word(n);
    chk_word(24'h40_0000, 24'hC0_0000);
    rd(4'h4, d); chk(d & 32'h3, 32'h0000_0003);
    pat <= 2'h2;
    repeat (8) next_word(n);
    chk_word(24'h00_0000, 24'h00_0000);
    pat <= 2'h1;
    repeat (8) next_word(n);
    chk_word(24'hC0_0000, 24'h40_0000);
    // Resync restarts settling; 432 ticks are 864 clocks.
    wr(4'h0, 32'h0000_0130);
    rd(4'h4, d); chk(d & 32'h3, 32'h0000_0000);
    repeat (820) @(posedge clk_in);
    rd(4'h4, d); chk(d & 32'h3, 32'h0000_0000);
    repeat (100) @(posedge clk_in);
    rd(4'h4, d); chk(d & 32'h3, 32'h0000_0003);
    @(posedge clk_in) cfg <= 2'h2;
    @(posedge clk_in) cfg <= 2'h0;
    rd(4'h4, d); chk(d & 32'h3, 32'h0000_0001);
    // Stall through three boundaries: two words kept, the third dropped.
    next_word(n);
    @(posedge clk_in) stall <= 1'b1;
    repeat (770) @(posedge clk_in);
    chk({31'h0, valid}, 32'h0000_0001);
    rd(4'h4, d); chk(d & 32'h8, 32'h0000_0008);
    rd(4'h4, d); chk(d & 32'h8, 32'h0000_0000);
    @(posedge clk_in) stall <= 1'b0;
    @(posedge clk_in);
    #1 chk({31'h0, valid}, 32'h0000_0001);
    @(posedge clk_in);
    #1 chk({31'h0, valid}, 32'h0000_0000);
    // Every ratio code after a resync; the first word lands twice the ratio in clocks later.
    // The free-running tick may take one clock off, which the halving with rounding absorbs.
    for (int k = 0; k < 8; k++) begin
      wr(4'h0, 32'h0000_0130 | k);
      next_word(n); chk(32'((n + 1) >> 1), 32'(128 << k));
    end
    wr(4'h0, 32'h0000_0037);
    rd(4'h0, d); chk(d, 32'h0000_0037);
    // A second reset returns to the fast path and the default ratio.
    @(posedge clk_in) rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(4'h0, d); chk(d, 32'h0000_0030);
    rd(4'h4, d); chk(d & 32'h4, 32'h0000_0000);
    end_of_test();
  end
endmodule
